// File: design/dpt_pkg.sv
// shared constants and carriers for the dual-port pseudo-i2s transmitter
package dpt_pkg;

  // system clock
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CLK_HZ         = 100_000_000;

  // codec master clock from the compare output
  localparam int MCLK_HZ        = 25_000_000;
  localparam int MCLK_HALF_CYC  = CLK_HZ / (2 * MCLK_HZ);

  // codec reset pulse, least time, rounded up
  localparam int RST_PULSE_NS   = 1000;
  localparam int RST_PULSE_CYC  =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // i2c quarter bit at 100 kHz, longest time, rounded down
  localparam int I2C_QUARTER_NS  = 2500;
  localparam int I2C_QUARTER_CYC = I2C_QUARTER_NS / CLK_PERIOD_NS;

  // one write: address, register, data, each with an ack slot
  localparam int I2C_FRAME_BITS = 27;
  localparam int I2C_BYTE_SLOTS = 9;

  // audio word per channel
  localparam int SAMPLE_W       = 16;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } dpt_sample_s;

  typedef struct packed {
    logic [6:0] dev;
    logic [7:0] reg_addr;
    logic [7:0] data;
  } dpt_cfg_s;

  typedef enum logic [1:0] {
    I2C_IDLE,
    I2C_START,
    I2C_BITS,
    I2C_STOP
  } dpt_i2c_e;

endpackage

// File: design/dpt_tx.sv
// dual slave serial ports forming a transmit-only pseudo-i2s link
//
// Functional notes
// - link is bit clock, word clock, data
// - both ports are slaves on codec clocks
// - word clock selects exactly one port
// - port b sees word clock inverted
// - 25 MHz master clock from compare output
// - active-low codec reset driven low
// - reset pulse precedes audio and configuration
// - codec registers written over i2c
// - both transmit outputs share codec data input
`timescale 1ns/1ns
module dpt_tx (
  // system
  input  wire logic               clk,
  input  wire logic               nrst,
  // link clocks from the codec
  input  wire logic               bit_clock,
  input  wire logic               word_clock,
  // sample stream
  input  wire logic               sample_valid,
  input  wire dpt_pkg::dpt_sample_s sample,
  output logic                    sample_ready,
  // codec register writes
  input  wire logic               cfg_valid,
  input  wire dpt_pkg::dpt_cfg_s  cfg,
  output logic                    cfg_ready,
  output logic                    cfg_nack,
  // codec control
  input  wire logic               codec_restart,
  output logic                    codec_reset_n,
  output logic                    codec_ready,
  output logic                    timer_compare_output,
  // i2c open-drain pins
  input  wire logic               scl_i,
  output logic                    scl_o,
  output logic                    scl_oe_n,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n,
  // shared data line, one driver per port
  output logic                    port_a_transmit,
  output logic                    port_a_transmit_oe_n,
  output logic                    port_b_transmit,
  output logic                    port_b_transmit_oe_n
);

  // master clock
  logic [1:0] mclk_cnt;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mclk_cnt             <= 2'h0;
      timer_compare_output <= 1'b0;
    end else if (mclk_cnt == 2'(dpt_pkg::MCLK_HALF_CYC - 1)) begin
      mclk_cnt             <= 2'h0;
      timer_compare_output <= ~timer_compare_output;
    end else begin
      mclk_cnt             <= mclk_cnt + 2'h1;
    end
  end

  // codec reset
  logic [7:0] rst_cnt;

  // hold reset line low for the pulse
  // ready only after the pulse ends
  always_ff @(posedge clk) begin
    if (!nrst || codec_restart) begin
      rst_cnt       <= 8'h00;
      codec_reset_n <= 1'b0;
      codec_ready   <= 1'b0;
    end else if (rst_cnt != 8'(dpt_pkg::RST_PULSE_CYC - 1)) begin
      rst_cnt       <= rst_cnt + 8'h01;
    end else begin
      codec_reset_n <= 1'b1;
      codec_ready   <= 1'b1;
    end
  end

  // i2c writer
  dpt_pkg::dpt_i2c_e               i2c_state;
  logic [7:0]                      qcnt;
  logic [1:0]                      phase;
  logic [4:0]                      bit_cnt;
  logic [3:0]                      slot;
  logic [dpt_pkg::I2C_FRAME_BITS-1:0] shreg;
  logic                            scl_meta;
  logic                            scl_s;
  logic                            sda_meta;
  logic                            sda_s;
  logic                            tick;
  logic                            stretch;

  // open drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  always_ff @(posedge clk) begin
    scl_meta <= scl_i;
    scl_s    <= scl_meta;
    sda_meta <= sda_i;
    sda_s    <= sda_meta;
  end

  // a slow target may hold scl low; wait for it
  assign stretch = (i2c_state == dpt_pkg::I2C_BITS) && (phase == 2'h1)
                   && scl_oe_n && !scl_s;
  assign tick    = (qcnt == 8'(dpt_pkg::I2C_QUARTER_CYC - 1));

  always_ff @(posedge clk) begin
    if (!nrst || i2c_state == dpt_pkg::I2C_IDLE || tick) begin
      qcnt <= 8'h00;
    end else if (!stretch) begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      i2c_state <= dpt_pkg::I2C_IDLE;
      phase     <= 2'h0;
      bit_cnt   <= 5'h00;
      slot      <= 4'h0;
      shreg     <= '0;
      scl_oe_n  <= 1'b1;
      sda_oe_n  <= 1'b1;
      cfg_ready <= 1'b0;
      cfg_nack  <= 1'b0;
    end else begin
      case (i2c_state)
        dpt_pkg::I2C_IDLE: begin
          // no configuration before the reset pulse
          if (cfg_valid && cfg_ready) begin
            cfg_ready <= 1'b0;
            cfg_nack  <= 1'b0;
            shreg     <= {cfg.dev, 1'b0, 1'b1, cfg.reg_addr, 1'b1,
                          cfg.data, 1'b1};
            sda_oe_n  <= 1'b0;
            i2c_state <= dpt_pkg::I2C_START;
          end else begin
            cfg_ready <= codec_ready && !codec_restart;
          end
        end
        dpt_pkg::I2C_START: begin
          if (tick) begin
            scl_oe_n  <= 1'b0;
            phase     <= 2'h0;
            bit_cnt   <= 5'h00;
            slot      <= 4'h0;
            i2c_state <= dpt_pkg::I2C_BITS;
          end
        end
        dpt_pkg::I2C_BITS: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: scl_oe_n <= 1'b1;
              2'h1: begin
                if (slot == 4'(dpt_pkg::I2C_BYTE_SLOTS - 1) && sda_s) begin
                  cfg_nack <= 1'b1;
                end
              end
              2'h2: scl_oe_n <= 1'b0;
              default: begin
                shreg   <= {shreg[dpt_pkg::I2C_FRAME_BITS-2:0], 1'b1};
                bit_cnt <= bit_cnt + 5'h01;
                slot    <= (slot == 4'(dpt_pkg::I2C_BYTE_SLOTS - 1))
                           ? 4'h0 : slot + 4'h1;
                if (bit_cnt == 5'(dpt_pkg::I2C_FRAME_BITS - 1)) begin
                  sda_oe_n  <= 1'b0;
                  phase     <= 2'h0;
                  i2c_state <= dpt_pkg::I2C_STOP;
                end
              end
            endcase
          end else if (phase == 2'h0) begin
            // data changes only while scl is low
            sda_oe_n <= shreg[dpt_pkg::I2C_FRAME_BITS-1];
          end
        end
        dpt_pkg::I2C_STOP: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (phase == 2'h0) begin
              scl_oe_n <= 1'b1;
            end else begin
              sda_oe_n  <= 1'b1;
              i2c_state <= dpt_pkg::I2C_IDLE;
            end
          end
        end
        default: i2c_state <= dpt_pkg::I2C_IDLE;
      endcase
    end
  end

  // sample hand-over, clk side
  dpt_pkg::dpt_sample_s hold;
  logic                 req_tgl;
  logic                 ack_meta;
  logic                 ack_s;
  logic                 ack_tgl;

  always_ff @(posedge clk) begin
    ack_meta <= ack_tgl;
    ack_s    <= ack_meta;
  end

  // hold stays stable until the link side acknowledges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold         <= '0;
      req_tgl      <= 1'b0;
      sample_ready <= 1'b0;
    end else if (sample_valid && sample_ready) begin
      hold         <= sample;
      req_tgl      <= ~req_tgl;
      sample_ready <= 1'b0;
    end else begin
      // no audio before the reset pulse
      sample_ready <= codec_ready && !codec_restart && (ack_s == req_tgl);
    end
  end

  // link side, on the codec bit clock
  // both link clocks are inputs only
  logic                 lrst_meta;
  logic                 lrst;
  logic                 req_meta;
  logic                 req_s;
  logic                 wclk_prev;
  dpt_pkg::dpt_sample_s staged;
  logic [1:0]           tx_bit;
  logic [1:0]           tx_oe_n;
  logic [1:0]           frame_select;

  // shift on the falling edge so the codec samples on the rising one
  always_ff @(negedge bit_clock) begin
    lrst_meta <= nrst;
    lrst      <= lrst_meta;
    req_meta  <= req_tgl;
    req_s     <= req_meta;
  end

  // word clock framed against bit clock; same domain, no sync
  // low selects port a, high selects port b
  assign frame_select[0] = word_clock;
  assign frame_select[1] = ~word_clock;

  // new sample taken as the right half starts, so both halves match
  always_ff @(negedge bit_clock) begin
    if (!lrst) begin
      wclk_prev <= 1'b0;
      staged    <= '0;
      ack_tgl   <= 1'b0;
    end else begin
      wclk_prev <= word_clock;
      if (word_clock && !wclk_prev && req_s != ack_tgl) begin
        staged  <= hold;
        ack_tgl <= req_s;
      end
    end
  end

  // two identical slave ports on the codec clocks
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [dpt_pkg::SAMPLE_W-1:0] sreg;
    logic [dpt_pkg::SAMPLE_W-1:0] word;

    assign word = (p == 0) ? staged.left : staged.right;

    always_ff @(negedge bit_clock) begin
      if (!lrst) begin
        sreg       <= '0;
        tx_bit[p]  <= 1'b0;
        tx_oe_n[p] <= 1'b1;
      end else if (frame_select[p]) begin
        // deselected: release the line, preload the word
        sreg       <= word;
        tx_bit[p]  <= 1'b0;
        tx_oe_n[p] <= 1'b1;
      end else begin
        // msb one bit after the word clock edge; zeros past the word
        tx_bit[p]  <= sreg[dpt_pkg::SAMPLE_W-1];
        sreg       <= {sreg[dpt_pkg::SAMPLE_W-2:0], 1'b0};
        tx_oe_n[p] <= 1'b0;
      end
    end
  end

  // both drivers meet on the codec data input
  assign port_a_transmit      = tx_bit[0];
  assign port_a_transmit_oe_n = tx_oe_n[0];
  assign port_b_transmit      = tx_bit[1];
  assign port_b_transmit_oe_n = tx_oe_n[1];

endmodule

// File: test/dpt_chk.sv
// port assertions for the pseudo-i2s transmitter
`timescale 1ns/1ns
module dpt_chk (
  // system
  input wire logic clk,
  input wire logic nrst,
  // link clocks
  input wire logic bit_clock,
  input wire logic word_clock,
  // handshakes
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic cfg_valid,
  input wire logic cfg_ready,
  // codec control and pins
  input wire logic codec_reset_n,
  input wire logic codec_ready,
  input wire logic timer_compare_output,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic port_a_transmit_oe_n,
  input wire logic port_b_transmit_oe_n
);
  // clocks of codec reset low since release, saturating
  logic [11:0] low_cnt;
  always_ff @(posedge clk) begin
    if (codec_reset_n || !nrst)
      low_cnt <= 12'h000;
    else if (low_cnt != 12'hFFF)
      low_cnt <= low_cnt + 12'h001;
  end

  chk_one_driver: assert property (@(posedge clk) disable iff (!nrst)
    port_a_transmit_oe_n || port_b_transmit_oe_n) else $error("two drivers");
  chk_left_port: assert property (@(negedge bit_clock) disable iff (!nrst)
    !word_clock [*8] |-> !port_a_transmit_oe_n && port_b_transmit_oe_n)
    else $error("left half not port a");
  chk_right_port: assert property (@(negedge bit_clock) disable iff (!nrst)
    word_clock [*8] |-> !port_b_transmit_oe_n && port_a_transmit_oe_n)
    else $error("right half not port b");
  chk_mclk_rate: assert property (@(posedge clk) disable iff (!nrst)
    $changed(timer_compare_output) |=> $stable(timer_compare_output)
    ##1 $changed(timer_compare_output)) else $error("master clock rate");
  chk_rst_pulse: assert property (@(posedge clk) disable iff (!nrst)
    $rose(codec_reset_n) |-> low_cnt >= 12'(dpt_pkg::RST_PULSE_CYC - 1))
    else $error("codec reset pulse short");
  chk_ready_rst: assert property (@(posedge clk) disable iff (!nrst)
    codec_ready |-> codec_reset_n) else $error("ready in codec reset");
  chk_req_gate: assert property (@(posedge clk) disable iff (!nrst)
    cfg_ready || sample_ready |-> codec_ready) else $error("ready too early");
  chk_i2c_start: assert property (@(posedge clk) disable iff (!nrst)
    cfg_valid && cfg_ready |=> !cfg_ready ##[0:1] (!sda_oe_n && scl_oe_n))
    else $error("no start condition");
  chk_sample_take: assert property (@(posedge clk) disable iff (!nrst)
    sample_valid && sample_ready |=> !sample_ready) else $error("not taken");

  cov_cfg: cover property (@(posedge clk) cfg_valid && cfg_ready);
  cov_smp: cover property (@(posedge clk) sample_valid && sample_ready);
  cov_rdy: cover property (@(posedge clk) $rose(codec_ready));
endmodule

bind dpt_tx dpt_chk u_chk (.clk, .nrst, .bit_clock, .word_clock,
  .sample_valid, .sample_ready, .cfg_valid, .cfg_ready, .codec_reset_n,
  .codec_ready, .timer_compare_output, .scl_oe_n, .sda_oe_n,
  .port_a_transmit_oe_n, .port_b_transmit_oe_n);

// File: test/dpt_codec_model.sv
// codec model: masters link clocks, captures words, acks i2c bytes
`timescale 1ns/1ns
module dpt_codec_model #(
  parameter int HALF_BITS = 20
) (
  // link, codec side
  output logic        bit_clock,
  output logic        word_clock,
  input  wire logic   data_line,
  // i2c wires
  input  wire logic   scl,
  input  wire logic   sda,
  input  wire logic   ack_en,
  output logic        sda_pull,
  // captured words
  output logic [15:0] left_word,
  output logic [15:0] right_word,
  output logic [7:0]  frames,
  output logic [27:0] i2c_bits
);
  logic [4:0]  half_cnt = 5'h00;
  logic [4:0]  bit_idx  = 5'h00;
  logic [4:0]  falls    = 5'h00;
  logic [15:0] shift;
  logic        wc_q     = 1'b0;
  initial begin
    word_clock = 1'b0;
    sda_pull = 1'b0;
    frames = 8'h00;
    bit_clock = 1'b1;
    #3;
    forever begin
      bit_clock = ~bit_clock;
      #16;
    end
  end
  always @(negedge bit_clock) begin
    half_cnt <= (half_cnt == 5'(HALF_BITS - 1)) ? 5'h00 : half_cnt + 5'h01;
    if (half_cnt == 5'(HALF_BITS - 1))
      word_clock <= ~word_clock;
  end
  // one-bit delay, sixteen bits msb first
  always @(posedge bit_clock) begin
    wc_q <= word_clock;
    if (word_clock != wc_q) begin
      bit_idx <= 5'h01;
      if (wc_q) begin
        right_word <= shift;
        frames <= frames + 8'h01;
      end else
        left_word <= shift;
    end else if (bit_idx <= 5'h10) begin
      shift <= {shift[14:0], data_line};
      bit_idx <= bit_idx + 5'h01;
    end
  end
  // every bit on scl rise; the stop's rise adds a low last
  always @(posedge scl) i2c_bits <= {i2c_bits[26:0], sda};
  // pull sda low through each ninth slot
  always @(negedge sda) if (scl) falls <= 5'h00;
  always @(negedge scl) begin
    falls <= falls + 5'h01;
    sda_pull <= ack_en && (falls == 5'h08 || falls == 5'h11 || falls == 5'h1A);
  end
endmodule

// File: test/tb.sv
// self-checking bench for the pseudo-i2s transmitter
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic nrst, sample_valid, cfg_valid, codec_restart, ack_en;
  logic bit_clock, word_clock, sample_ready, cfg_ready, cfg_nack;
  logic codec_reset_n, codec_ready, timer_compare_output, sda_pull;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, last_bit = 1'b0;
  logic port_a_transmit, port_a_transmit_oe_n;
  logic port_b_transmit, port_b_transmit_oe_n;
  logic [15:0] left_word, right_word;
  logic [7:0] frames;
  logic [27:0] i2c_bits;
  dpt_pkg::dpt_sample_s sample;
  dpt_pkg::dpt_cfg_s cfg;
  int fails = 0, cmp_count = 0;
  wire scl_i = !(!scl_oe_n && !scl_o);
  wire sda_i = !((!sda_oe_n && !sda_o) || sda_pull);
  // undriven line flips so a stale bit never passes
  wire data_line = !port_a_transmit_oe_n ? port_a_transmit :
    !port_b_transmit_oe_n ? port_b_transmit : ~last_bit;

  initial forever #5 clk = ~clk;
  always @(posedge bit_clock) last_bit <= data_line;
  dpt_tx dut (.clk, .nrst, .bit_clock, .word_clock, .sample_valid, .sample,
    .sample_ready, .cfg_valid, .cfg, .cfg_ready, .cfg_nack, .codec_restart,
    .codec_reset_n, .codec_ready, .timer_compare_output, .scl_i, .scl_o,
    .scl_oe_n, .sda_i, .sda_o, .sda_oe_n, .port_a_transmit,
    .port_a_transmit_oe_n, .port_b_transmit, .port_b_transmit_oe_n);
  dpt_codec_model codec (.bit_clock, .word_clock, .data_line, .scl(scl_i),
    .sda(sda_i), .ack_en, .sda_pull, .left_word, .right_word, .frames,
    .i2c_bits);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(inout int n, input int lim);
    @(negedge clk);
    n++;
    if (n > lim) begin
      fails++;
      $display("timeout at %0t", $time);
      end_sim();
    end
  endtask
  task automatic t_pulse();
    int n = 0;
    while (codec_reset_n !== 1'b1) tick(n, 500);
    check(32'(n - dpt_pkg::RST_PULSE_CYC) >> 1, 32'h0);
    check(codec_ready, 1'b1);
    tick(n, 500);
    check({cfg_ready, sample_ready}, 2'h3);
    $display("test reset pulse done");
  endtask
  task automatic t_cfg(input logic ack, input logic exp_nack);
    int n = 0;
    logic [27:0] exp_bits;
    ack_en = ack;
    exp_bits = {7'h1B, 1'b0, ~ack, 8'h2C, ~ack, 8'h5E, ~ack, 1'b0};
    while (cfg_ready !== 1'b1) tick(n, 100);
    cfg = {7'h1B, 8'h2C, 8'h5E};
    cfg_valid = 1'b1;
    @(negedge clk);
    cfg_valid = 1'b0;
    check(cfg_ready, 1'b0);
    while (cfg_ready !== 1'b1) tick(n, 40000);
    check(cfg_nack, exp_nack);
    check(i2c_bits, exp_bits);
    $display("test config write done");
  endtask
  task automatic t_audio();
    int n = 0;
    logic [7:0] f;
    while (sample_ready !== 1'b1) tick(n, 2000);
    sample = {16'hA5C3, 16'h3C5A};
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    check(sample_ready, 1'b0);
    f = frames;
    while (8'(frames - f) < 8'h04) tick(n, 3000);
    check(left_word, 16'hA5C3);
    check(right_word, 16'h3C5A);
    $display("test audio frame done");
  endtask

  initial begin
    {nrst, sample_valid, cfg_valid, codec_restart, ack_en} = 5'h00;
    sample = 32'h0;
    cfg = 23'h0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    t_pulse();
    t_cfg(1'b1, 1'b0);
    t_cfg(1'b0, 1'b1);
    t_audio();
    codec_restart = 1'b1;
    @(negedge clk);
    codec_restart = 1'b0;
    check({codec_reset_n, codec_ready}, 2'h0);
    t_pulse();
    end_sim();
  end
endmodule
